// file: rtl/ctlp_calib_trigger_lowpower_ctrl.sv
`timescale 1ns/1ps
`include "ctlp_defs.svh"

// Summary of operation
// - status-select code 0 foreground-done, 1 stopped, 2 alarm, 3 pin held low.
// - trigger-source bit 0 takes software trigger bit, hardware trigger pin ignored.
// - trigger-source bit 1 takes hardware trigger pin, software trigger bit ignored.
// - sleep-delay code picks k, sleep lasts (2^k+1)*256 clocks; reset code 4.
// - sleep delay counts only with low power enabled and trigger sleep off.
// - wake-delay code picks k, settling lasts (2^k+1)*256 clocks; reset code 1.
// - trigger sleep off means autonomous sleep for the programmed sleep delay.
// - trigger sleep on means sleep until the selected trigger goes low.
// - low-power enable works only while background calibration is enabled.
// - background enable bit, reset zero, gates low-power background calibration.
// - foreground-done input is one selectable source of the status pin.
// - calibration-stopped input is another selectable source of the status pin.
module ctlp_calib_trigger_lowpower_ctrl #(
    parameter int unsigned DLY_EXP_REDUCE = 0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hardware_calibration_trigger_pin,
    input wire logic foreground_done,
    input wire logic calibration_stopped,
    input wire logic alarm,
    input wire logic cal_phase_done,
    output logic calibration_status_pin,
    output logic adc_sleep,
    output logic cal_start,
    output logic irq
);

    ctlp_pkg::ctlp_state_t st;
    ctlp_pkg::ctlp_state_t next_st;

    logic [7:0] reg_index;
    logic lp_active;
    logic trig_mode;
    logic trig_level;
    logic [3:0] events;
    logic wr_ok;
    logic [1:0] stat_sel;
    logic trig_hw;
    logic [`CTLP_CNT_W-1:0] sleep_load;
    logic [`CTLP_CNT_W-1:0] wake_load;

    // cycle count for a delay of (2^k + 1) * unit, minus one for a down-counter
    function automatic logic [41:0] dly_cycles(input logic [5:0] k);
        logic [5:0] k_eff;
        logic [41:0] span;
        k_eff = (k > 6'(DLY_EXP_REDUCE)) ? k - 6'(DLY_EXP_REDUCE) : 6'd0;
        span = (42'h1 << k_eff) + 42'h1;
        return span * `CTLP_DLY_UNIT - 42'h1;
    endfunction

    // exponent tables of the two delay fields
    function automatic logic [5:0] sleep_exp(input logic [2:0] code);
        case (code)
            3'd0: sleep_exp = `CTLP_SLEEP_K0;
            3'd1: sleep_exp = `CTLP_SLEEP_K1;
            3'd2: sleep_exp = `CTLP_SLEEP_K2;
            3'd3: sleep_exp = `CTLP_SLEEP_K3;
            3'd4: sleep_exp = `CTLP_SLEEP_K4;
            3'd5: sleep_exp = `CTLP_SLEEP_K5;
            3'd6: sleep_exp = `CTLP_SLEEP_K6;
            default: sleep_exp = `CTLP_SLEEP_K7;
        endcase
    endfunction

    function automatic logic [5:0] wake_exp(input logic [1:0] code);
        case (code)
            2'd0: wake_exp = `CTLP_WAKE_K0;
            2'd1: wake_exp = `CTLP_WAKE_K1;
            2'd2: wake_exp = `CTLP_WAKE_K2;
            default: wake_exp = `CTLP_WAKE_K3;
        endcase
    endfunction

    // decoded controls
    assign reg_index = avs_address[9:2];
    assign lp_active = st.low_power[`CTLP_LOW_POWER_CALIBRATION_ENABLE_BIT] & st.bg_cfg[`CTLP_BG_EN_BIT];
    assign trig_mode = st.low_power[`CTLP_TRIGGER_DRIVEN_SLEEP_BIT];
    assign stat_sel = st.pin_cfg[`CTLP_STAT_SEL_HI:`CTLP_STAT_SEL_LO];
    assign trig_hw = st.pin_cfg[`CTLP_TRIG_SRC_BIT];
    assign trig_level = trig_hw ? st.trig_s2
                                                      : st.soft_trig[`CTLP_SOFT_TRIG_BIT];
    assign sleep_load = dly_cycles(sleep_exp(st.low_power[`CTLP_SLEEP_HI:`CTLP_SLEEP_LO]));
    assign wake_load = dly_cycles(wake_exp(st.low_power[`CTLP_WAKE_HI:`CTLP_WAKE_LO]));
    assign wr_ok = avs_write & ~st.waitrequest & avs_byteenable[0];

    // next state of the whole block
    always_comb begin
        next_st = st;
        events = 4'h0;
        next_st.cal_start = 1'b0;
        // hardware trigger synchroniser
        next_st.trig_s1 = hardware_calibration_trigger_pin;
        next_st.trig_s2 = st.trig_s1;
        // rising edges of status inputs become interrupt events
        next_st.prev_foreground_done = foreground_done;
        next_st.prev_stopped = calibration_stopped;
        next_st.prev_alarm = alarm;
        events[`CTLP_IRQ_FOREGROUND_DONE] = foreground_done & ~st.prev_foreground_done;
        events[`CTLP_IRQ_STOPPED] = calibration_stopped & ~st.prev_stopped;
        events[`CTLP_IRQ_ALARM] = alarm & ~st.prev_alarm;

        // status pin routing
        case (stat_sel)
            2'd0: next_st.status_pin = foreground_done;
            2'd1: next_st.status_pin = calibration_stopped;
            2'd2: next_st.status_pin = alarm;
            default: next_st.status_pin = 1'b0;
        endcase

        // low-power sleep and wake sequencer
        case (st.lp_state)
            ctlp_pkg::CTLP_LP_OFF: begin
                if (lp_active) begin
                    next_st.lp_state = ctlp_pkg::CTLP_LP_SLEEP;
                    next_st.count = sleep_load;
                end
            end
            ctlp_pkg::CTLP_LP_SLEEP: begin
                if (trig_mode) begin
                    if (!trig_level) begin
                        next_st.lp_state = ctlp_pkg::CTLP_LP_WAKE;
                        next_st.count = wake_load;
                        events[`CTLP_IRQ_WAKE] = 1'b1;
                    end
                end else if (st.count == 42'h0) begin
                    next_st.lp_state = ctlp_pkg::CTLP_LP_WAKE;
                    next_st.count = wake_load;
                    events[`CTLP_IRQ_WAKE] = 1'b1;
                end else begin
                    next_st.count = st.count - 42'h1;
                end
            end
            ctlp_pkg::CTLP_LP_WAKE: begin
                if (st.count == 42'h0) begin
                    next_st.lp_state = ctlp_pkg::CTLP_LP_CAL;
                    next_st.cal_start = 1'b1;
                end else begin
                    next_st.count = st.count - 42'h1;
                end
            end
            ctlp_pkg::CTLP_LP_CAL: begin
                if (cal_phase_done) begin
                    next_st.lp_state = ctlp_pkg::CTLP_LP_SLEEP;
                    next_st.count = sleep_load;
                end
            end
            default: begin
                next_st.lp_state = ctlp_pkg::CTLP_LP_OFF;
            end
        endcase
        // losing either enable stops the sequencer at once
        if (!lp_active) begin
            next_st.lp_state = ctlp_pkg::CTLP_LP_OFF;
            next_st.count = 42'h0;
            events[`CTLP_IRQ_WAKE] = 1'b0; // no wake is reported while shutting down
        end
        next_st.adc_sleep = (next_st.lp_state == ctlp_pkg::CTLP_LP_SLEEP);

        // register bus: answer one cycle after the request is seen
        if ((avs_read | avs_write) & st.waitrequest) begin
            next_st.waitrequest = 1'b0;
            case (reg_index)
                `CTLP_IDX_BG_CFG: next_st.readdata = st.bg_cfg;
                `CTLP_IDX_PIN_CFG: next_st.readdata = st.pin_cfg;
                `CTLP_IDX_SOFT_TRIG: next_st.readdata = st.soft_trig;
                `CTLP_IDX_LOW_POWER: next_st.readdata = st.low_power;
                `CTLP_IDX_IRQ_STATUS: next_st.readdata = {4'h0, st.irq_status};
                `CTLP_IDX_IRQ_MASK: next_st.readdata = {4'h0, st.irq_mask};
                default: next_st.readdata = 8'h00;
            endcase
        end else begin
            next_st.waitrequest = 1'b1;
        end
        // writes take effect on the accepting edge
        if (wr_ok) begin
            case (reg_index)
                `CTLP_IDX_BG_CFG: next_st.bg_cfg = avs_writedata[7:0];
                `CTLP_IDX_PIN_CFG: next_st.pin_cfg = avs_writedata[7:0];
                `CTLP_IDX_SOFT_TRIG: next_st.soft_trig = avs_writedata[7:0];
                `CTLP_IDX_LOW_POWER: next_st.low_power = avs_writedata[7:0];
                `CTLP_IDX_IRQ_STATUS: next_st.irq_status = st.irq_status & ~avs_writedata[3:0];
                `CTLP_IDX_IRQ_MASK: next_st.irq_mask = avs_writedata[3:0];
                default: next_st.bg_cfg = st.bg_cfg;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_st.irq_status = next_st.irq_status | events;
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.bg_cfg <= `CTLP_RST_BG_CFG;
            st.pin_cfg <= `CTLP_RST_PIN_CFG;
            st.soft_trig <= `CTLP_RST_SOFT_TRIG;
            st.low_power <= `CTLP_RST_LOW_POWER;
            st.irq_status <= `CTLP_RST_IRQ;
            st.irq_mask <= `CTLP_RST_IRQ;
            st.lp_state <= ctlp_pkg::CTLP_LP_OFF;
            st.waitrequest <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign avs_readdata = {24'h00_0000, st.readdata};
    assign avs_waitrequest = st.waitrequest;
    assign calibration_status_pin = st.status_pin;
    assign adc_sleep = st.adc_sleep;
    assign cal_start = st.cal_start;
    assign irq = st.irq;

    // checks
    default clocking ast_clk @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    AST_SEL_LOW: assert property (
        (stat_sel == 2'd3) |=> !calibration_status_pin)
        else $error("status pin not low for select code 3");

    AST_SEL_FG: assert property (
        (stat_sel == 2'd0) |=> (calibration_status_pin == $past(foreground_done)))
        else $error("status pin does not follow foreground done");

    AST_SEL_STOP: assert property (
        (stat_sel == 2'd1) |=> (calibration_status_pin == $past(calibration_stopped)))
        else $error("status pin does not follow calibration stopped");

    AST_SEL_ALARM: assert property (
        (stat_sel == 2'd2) |=> (calibration_status_pin == $past(alarm)))
        else $error("status pin does not follow the alarm");

    AST_SW_SOURCE: assert property (
        (lp_active && trig_mode && !trig_hw && st.soft_trig[`CTLP_SOFT_TRIG_BIT]
         && st.lp_state == ctlp_pkg::CTLP_LP_SLEEP && !st.trig_s2)
        |=> (st.lp_state == ctlp_pkg::CTLP_LP_SLEEP) || !$past(lp_active, 1) || !lp_active)
        else $error("hardware pin woke the converter in software source mode");

    AST_HW_SOURCE: assert property (
        (lp_active && trig_mode && trig_hw && !st.trig_s2
         && st.lp_state == ctlp_pkg::CTLP_LP_SLEEP)
        |=> (st.lp_state == ctlp_pkg::CTLP_LP_WAKE) && !adc_sleep)
        else $error("low hardware trigger did not wake the converter");

    AST_TRIG_HOLD: assert property (
        (lp_active && trig_mode && trig_level && st.lp_state == ctlp_pkg::CTLP_LP_SLEEP
         && $stable(st.low_power)) |=> adc_sleep)
        else $error("converter woke with the trigger high");

    AST_TRIG_COUNT: assert property (
        (lp_active && trig_mode && trig_level && st.lp_state == ctlp_pkg::CTLP_LP_SLEEP)
        |=> $stable(st.count))
        else $error("sleep counter moved in trigger-driven sleep");

    AST_SLEEP_LOAD: assert property (
        ($past(st.lp_state) != ctlp_pkg::CTLP_LP_SLEEP && st.lp_state == ctlp_pkg::CTLP_LP_SLEEP)
        |-> (st.count == $past(sleep_load)))
        else $error("sleep counter loaded with wrong length");

    AST_WAKE_LOAD: assert property (
        ($rose(st.lp_state == ctlp_pkg::CTLP_LP_WAKE)) |-> (st.count == $past(wake_load)))
        else $error("wake counter loaded with wrong length");

    AST_AUTO_WAKE: assert property (
        (lp_active && !trig_mode && st.lp_state == ctlp_pkg::CTLP_LP_SLEEP && st.count == 42'h1)
        ##1 (lp_active && !trig_mode) |=> (st.lp_state == ctlp_pkg::CTLP_LP_WAKE))
        else $error("autonomous sleep did not end on count");

    AST_SLEEP_DOWN: assert property (
        (lp_active && !trig_mode && st.lp_state == ctlp_pkg::CTLP_LP_SLEEP
         && st.count != 42'h0)
        |=> adc_sleep && (st.count == $past(st.count) - 42'h1))
        else $error("autonomous sleep counter did not step down");

    AST_WAKE_DOWN: assert property (
        (lp_active && st.lp_state == ctlp_pkg::CTLP_LP_WAKE && st.count != 42'h0)
        |=> !adc_sleep && (st.lp_state == ctlp_pkg::CTLP_LP_WAKE)
            && (st.count == $past(st.count) - 42'h1))
        else $error("wake settling counter did not step down");

    AST_CAL_PULSE: assert property (
        (lp_active && st.lp_state == ctlp_pkg::CTLP_LP_WAKE && st.count == 42'h0)
        |=> cal_start && (st.lp_state == ctlp_pkg::CTLP_LP_CAL))
        else $error("calibration did not start at the end of settling");

    AST_START_PULSE: assert property (
        cal_start |=> !cal_start)
        else $error("calibration start pulse longer than one cycle");

    AST_LP_ENTRY: assert property (
        (lp_active && st.lp_state == ctlp_pkg::CTLP_LP_OFF) |=> adc_sleep)
        else $error("enabled sequencer did not enter sleep");

    AST_LP_GATE: assert property (
        !lp_active |=> (st.lp_state == ctlp_pkg::CTLP_LP_OFF) && !adc_sleep)
        else $error("sequencer runs without both enables");

    AST_BUS_ANSWER: assert property (
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle wide");

    AST_BUS_WRITE: assert property (
        (wr_ok && reg_index == `CTLP_IDX_PIN_CFG) |=> (st.pin_cfg == $past(avs_writedata[7:0])))
        else $error("pin configuration write not stored");

    AST_BUS_READ: assert property (
        (avs_read && avs_waitrequest && reg_index == `CTLP_IDX_LOW_POWER)
        |=> (avs_readdata[7:0] == $past(st.low_power)))
        else $error("low-power register read returned wrong data");

    AST_IRQ_LEVEL: assert property (
        ##1 (irq == |(st.irq_status & st.irq_mask)))
        else $error("interrupt output disagrees with status and mask");

    AST_STAT_EVENT: assert property (
        $rose(foreground_done) |=> st.irq_status[`CTLP_IRQ_FOREGROUND_DONE])
        else $error("foreground done rise not latched as event");

    AST_WAKE_EVENT: assert property (
        $rose(st.lp_state == ctlp_pkg::CTLP_LP_WAKE) |-> st.irq_status[`CTLP_IRQ_WAKE])
        else $error("wake not latched as event");

    AST_SET_WINS: assert property (
        (events[`CTLP_IRQ_WAKE] && wr_ok && reg_index == `CTLP_IDX_IRQ_STATUS
         && avs_writedata[`CTLP_IRQ_WAKE]) |=> st.irq_status[`CTLP_IRQ_WAKE])
        else $error("clear in the same cycle lost a wake event");

    COV_HW_WAKE: cover property (
        trig_hw && trig_mode && $rose(st.lp_state == ctlp_pkg::CTLP_LP_WAKE));
    COV_SOFT_WAKE: cover property (
        !trig_hw && trig_mode && $rose(st.lp_state == ctlp_pkg::CTLP_LP_WAKE));
    COV_AUTO_WAKE: cover property (
        !trig_mode && $rose(st.lp_state == ctlp_pkg::CTLP_LP_WAKE));
    COV_CAL_START: cover property (cal_start);
    COV_IRQ: cover property ($rose(irq));

endmodule

// file: rtl/ctlp_defs.svh
`ifndef CTLP_DEFS_SVH
`define CTLP_DEFS_SVH

// register indices; byte address is four times the index
`define CTLP_IDX_BG_CFG 8'h62
`define CTLP_IDX_PIN_CFG 8'h6b
`define CTLP_IDX_SOFT_TRIG 8'h6c
`define CTLP_IDX_LOW_POWER 8'h6e
`define CTLP_IDX_IRQ_STATUS 8'h80
`define CTLP_IDX_IRQ_MASK 8'h81

// reset values
`define CTLP_RST_BG_CFG 8'h00
`define CTLP_RST_PIN_CFG 8'h00
`define CTLP_RST_SOFT_TRIG 8'h01
`define CTLP_RST_LOW_POWER 8'h88
`define CTLP_RST_IRQ 4'h0

// field positions
`define CTLP_BG_EN_BIT 1
`define CTLP_TRIG_SRC_BIT 0
`define CTLP_STAT_SEL_HI 2
`define CTLP_STAT_SEL_LO 1
`define CTLP_SOFT_TRIG_BIT 0
`define CTLP_SLEEP_HI 7
`define CTLP_SLEEP_LO 5
`define CTLP_WAKE_HI 4
`define CTLP_WAKE_LO 3
`define CTLP_TRIGGER_DRIVEN_SLEEP_BIT 1
`define CTLP_LOW_POWER_CALIBRATION_ENABLE_BIT 0

// interrupt bits
`define CTLP_IRQ_FOREGROUND_DONE 0
`define CTLP_IRQ_STOPPED 1
`define CTLP_IRQ_ALARM 2
`define CTLP_IRQ_WAKE 3

// timing: delay is (2^k + 1) * unit clock periods
`define CTLP_DLY_UNIT 42'h100
`define CTLP_CNT_W 42

// delay exponents k of the sleep-delay codes 0 to 7
`define CTLP_SLEEP_K0 6'h03
`define CTLP_SLEEP_K1 6'h0f
`define CTLP_SLEEP_K2 6'h12
`define CTLP_SLEEP_K3 6'h15
`define CTLP_SLEEP_K4 6'h18
`define CTLP_SLEEP_K5 6'h1b
`define CTLP_SLEEP_K6 6'h1e
`define CTLP_SLEEP_K7 6'h21

// delay exponents k of the wake-delay codes 0 to 3
`define CTLP_WAKE_K0 6'h03
`define CTLP_WAKE_K1 6'h12
`define CTLP_WAKE_K2 6'h15
`define CTLP_WAKE_K3 6'h18

`endif

// file: rtl/ctlp_pkg.sv
package ctlp_pkg;

    typedef enum logic [1:0] {
        CTLP_LP_OFF,
        CTLP_LP_SLEEP,
        CTLP_LP_WAKE,
        CTLP_LP_CAL
    } ctlp_lp_state_t;

    typedef struct packed {
        logic [7:0] bg_cfg;
        logic [7:0] pin_cfg;
        logic [7:0] soft_trig;
        logic [7:0] low_power;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic trig_s1;
        logic trig_s2;
        logic prev_foreground_done;
        logic prev_stopped;
        logic prev_alarm;
        ctlp_lp_state_t lp_state;
        logic [41:0] count;
        logic waitrequest;
        logic [7:0] readdata;
        logic status_pin;
        logic adc_sleep;
        logic cal_start;
        logic irq;
    } ctlp_state_t;

endpackage

// file: testbench/ctlp_engine_model.sv
`timescale 1ns/1ps

module ctlp_engine_model #(
    parameter int DONE_LAT = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cal_start,
    input wire logic [2:0] stat_cmd,
    input wire logic trig_cmd,
    output logic hardware_calibration_trigger_pin,
    output logic foreground_done,
    output logic calibration_stopped,
    output logic alarm,
    output logic cal_phase_done
);
    int cnt;

    // status levels and board trigger follow the bench's commands
    assign foreground_done = stat_cmd[0];
    assign calibration_stopped = stat_cmd[1];
    assign alarm = stat_cmd[2];
    assign hardware_calibration_trigger_pin = trig_cmd;

    // a calibration phase ends DONE_LAT cycles after each start pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            cal_phase_done <= 1'b0;
        end else begin
            cal_phase_done <= (cnt == 1);
            if (cal_start) begin
                cnt <= DONE_LAT;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// file: testbench/testbench.sv
`timescale 1ns/1ps
`include "ctlp_defs.svh"

module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, status_pin, adc_sleep, cal_start, irq;
    logic hw_pin, fg, stp, alm, phase_done;
    logic [2:0] stat_cmd = 3'h0;
    logic trig_cmd = 1'b1;
    logic [7:0] rd;
    logic [2:0] pv;
    int error_cnt = 0;
    int n_tests = 0;
    int n;

    // free-running system clock, 40 ns period
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    ctlp_calib_trigger_lowpower_ctrl #(.DLY_EXP_REDUCE(12)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hardware_calibration_trigger_pin(hw_pin),
        .foreground_done(fg), .calibration_stopped(stp), .alarm(alm),
        .cal_phase_done(phase_done), .calibration_status_pin(status_pin),
        .adc_sleep(adc_sleep), .cal_start(cal_start), .irq(irq));

    ctlp_engine_model eng (
        .clk_sys(clk_sys), .rst_n(rst_n), .cal_start(cal_start), .stat_cmd(stat_cmd),
        .trig_cmd(trig_cmd), .hardware_calibration_trigger_pin(hw_pin),
        .foreground_done(fg), .calibration_stopped(stp), .alarm(alm),
        .cal_phase_done(phase_done));

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one Avalon access; held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int t;
        t = 0;
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, wd};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk_sys);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            conclude();
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(what, rd, exp);
    endtask

    // counts edges until the chosen output is sampled at lvl
    task wait_for(input int sel, input logic lvl, input int lim, output int cnt);
        logic v;
        cnt = 0;
        v = ~lvl;
        while (v !== lvl && cnt < lim) begin
            @(posedge clk_sys);
            case (sel)
                0: v = adc_sleep;
                1: v = cal_start;
                default: v = irq;
            endcase
            if (v !== lvl) begin
                cnt++;
            end
        end
        if (v !== lvl) begin
            error_cnt++;
            conclude();
        end
    endtask

    // main sequence of register-level tests
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk("pin_cfg reset", `CTLP_IDX_PIN_CFG, 8'h00);
        rd_chk("soft_trig reset", `CTLP_IDX_SOFT_TRIG, 8'h01);
        rd_chk("low_power reset", `CTLP_IDX_LOW_POWER, 8'h88);
        rd_chk("bg_cfg reset", `CTLP_IDX_BG_CFG, 8'h00);
        rd_chk("irq_mask reset", `CTLP_IDX_IRQ_MASK, 8'h00);
        rd_chk("unmapped", 8'h10, 8'h00);
        // every status select code against every source pattern
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, `CTLP_IDX_PIN_CFG, {5'h00, s[1:0], 1'b0});
            for (int p = 0; p < 8; p++) begin
                @(posedge clk_sys);
                stat_cmd <= p[2:0];
                repeat (3) @(posedge clk_sys);
                pv = p[2:0];
                check("status_pin", status_pin, (s == 3) ? 1'b0 : pv[s]);
            end
        end
        rd_chk("pin_cfg readback", `CTLP_IDX_PIN_CFG, 8'h06);
        // low power enabled without background calibration stays awake
        bus(1'b1, `CTLP_IDX_LOW_POWER, 8'h29);
        repeat (50) @(posedge clk_sys);
        check("sleep without bg", adc_sleep, 1'b0);
        bus(1'b1, `CTLP_IDX_IRQ_MASK, 8'h08);
        bus(1'b1, `CTLP_IDX_BG_CFG, 8'h02);
        // autonomous cycle: sleep code 1 is k 3, wake code 1 is k 6
        wait_for(0, 1'b1, 20, n);
        wait_for(0, 1'b0, 3000, n);
        check("sleep length", n + 1, 2304);
        wait_for(1, 1'b1, 17000, n);
        check("wake length", n + 1, 16640);
        check("irq on wake", irq, 1'b1);
        bus(1'b0, `CTLP_IDX_IRQ_STATUS, 8'h00);
        check("wake status", rd, 8'h0f);
        bus(1'b1, `CTLP_IDX_IRQ_STATUS, 8'h08);
        bus(1'b0, `CTLP_IDX_IRQ_STATUS, 8'h00);
        check("wake cleared", rd, 8'h07);
        check("irq cleared", irq, 1'b0);
        wait_for(0, 1'b1, 200, n);
        // trigger-driven sleep, software source; board pin low is ignored
        bus(1'b1, `CTLP_IDX_LOW_POWER, 8'h00);
        bus(1'b1, `CTLP_IDX_LOW_POWER, 8'h2b);
        trig_cmd <= 1'b0;
        repeat (3000) @(posedge clk_sys);
        check("trig sleep holds", adc_sleep, 1'b1);
        bus(1'b1, `CTLP_IDX_SOFT_TRIG, 8'h00);
        wait_for(0, 1'b0, 10, n);
        check("soft wake", n <= 2, 1'b1);
        // hardware source; software bit is ignored
        bus(1'b1, `CTLP_IDX_SOFT_TRIG, 8'h01);
        bus(1'b1, `CTLP_IDX_LOW_POWER, 8'h00);
        trig_cmd <= 1'b1;
        bus(1'b1, `CTLP_IDX_PIN_CFG, 8'h01);
        bus(1'b1, `CTLP_IDX_LOW_POWER, 8'h2b);
        wait_for(0, 1'b1, 10, n);
        bus(1'b1, `CTLP_IDX_SOFT_TRIG, 8'h00);
        repeat (50) @(posedge clk_sys);
        check("soft ignored", adc_sleep, 1'b1);
        trig_cmd <= 1'b0;
        wait_for(0, 1'b0, 10, n);
        check("pin wake", n <= 4, 1'b1);
        conclude();
    end
endmodule
